// File: rtl/gpio_pad_pkg.sv
// Purpose: constants for the pad drive, open-drain and pull-up configuration block
// Assumes: one eight-line port, 32-bit register word, byte addresses
// Notes: pull-up reset differs per port instance
//
// Contract
// [RULE1] each high-drive bit configures only its own line
// [RULE2] writing high-drive 1 clears that line's low and medium drive bits
// [RULE3] low or medium drive write of 1 clears high-drive, seen second cycle
// [RULE4] high-drive field is bits 7:0, read/write, resets to zero
// [RULE5] bits 31:8 of each register are read-only zero
// [RULE6] open-drain field bits 7:0, resets zero, 1 enables open drain
// [RULE7] a line with direction cleared acts as input despite open drain
// [RULE8] open drain only takes effect once the line is an output
// [RULE9] software should also set digital enable when using open drain
// [RULE10] two-wire bus lines need open drain and alternate function set
// [RULE11] pull-up field bits 7:0; 1 turns the weak pull-up output on
// [RULE12] setting a pull-up bit clears the same line's pull-down bit
// [RULE13] pull-down write of 1 clears pull-up, seen second cycle
// [RULE14] pull-up reset is per port: zero, bit 7, or bits 3:0
// [RULE15] low-drive resets all ones; high and medium drive reset zero
// [RULE16] writing zero only stores zero, never touches other registers
`default_nettype none
package gpio_pad_pkg;
   localparam int LINES = 8;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] HIGH_DRIVE_OFS = 12'h508;
   localparam logic [ADDR_W-1:0] OPEN_DRAIN_OFS = 12'h50C;
   localparam logic [ADDR_W-1:0] PULL_UP_OFS = 12'h510;
   localparam logic [LINES-1:0] HIGH_DRIVE_RESET = 8'h00;
   localparam logic [LINES-1:0] OPEN_DRAIN_RESET = 8'h00;
   localparam logic [LINES-1:0] LOW_DRIVE_RESET = 8'hFF;
   localparam logic [LINES-1:0] PULL_UP_RESET_PLAIN = 8'h00;
   localparam logic [LINES-1:0] PULL_UP_RESET_PORT_B = 8'h80;
   localparam logic [LINES-1:0] PULL_UP_RESET_PORT_C = 8'h0F;
endpackage
`default_nettype wire

// File: rtl/pad_cfg_if.sv
// Purpose: carrier between the register core and its two helper stages
// Assumes: all signals on mclk
// Notes: no clocking, plain wires
`timescale 1ns/1ns
`default_nettype none
interface pad_cfg_if #(parameter int LINES = 8);
   logic ce;
   logic [LINES-1:0] drive_req;
   logic [LINES-1:0] pull_req;
   logic [LINES-1:0] drive_clr;
   logic [LINES-1:0] pull_clr;
   logic [LINES-1:0] open_drain;
   logic [LINES-1:0] pull_up;
   logic [LINES-1:0] dir;
   logic [LINES-1:0] od_active;
   logic [LINES-1:0] pu_active;
   modport core (output ce, drive_req, pull_req, open_drain, pull_up, dir,
      input drive_clr, pull_clr, od_active, pu_active);
   modport stage (input ce, drive_req, pull_req, output drive_clr, pull_clr);
   modport pads (input ce, open_drain, pull_up, dir, output od_active, pu_active);
endinterface
`default_nettype wire

// File: rtl/cross_clear_stage.sv
// Purpose: one-cycle stage for clears requested by neighbour registers
// Assumes: requests are one-cycle pulses on mclk
// Notes: the extra stage makes the clear visible on the second cycle
`timescale 1ns/1ns
`default_nettype none
module cross_clear_stage #(parameter int LINES = 8) (
   input wire logic mclk,
   input wire logic rstn,
   pad_cfg_if.stage bus
);
   typedef struct packed {
      logic [LINES-1:0] drive_clr;
      logic [LINES-1:0] pull_clr;
   } stage_t;
   stage_t q, d;

   always_comb begin
      d = q;
      if (bus.ce) begin
         d.drive_clr = bus.drive_req; // RULE3
         d.pull_clr = bus.pull_req; // RULE13
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bus.drive_clr = q.drive_clr;
   assign bus.pull_clr = q.pull_clr;
endmodule
`default_nettype wire

// File: rtl/pad_ctrl_out.sv
// Purpose: per-line pad controls from the stored configuration
// Assumes: direction comes from logic on mclk, so no synchroniser
// Notes: controls lag the registers by one cycle, kept glitch free
`timescale 1ns/1ns
`default_nettype none
module pad_ctrl_out #(parameter int LINES = 8) (
   input wire logic mclk,
   input wire logic rstn,
   pad_cfg_if.pads bus
);
   typedef struct packed {
      logic [LINES-1:0] od;
      logic [LINES-1:0] pu;
   } pads_t;
   pads_t q, d;
   logic [LINES-1:0] od_w;

   genvar i;
   generate
      for (i = 0; i < LINES; i++) begin : g_line
         // an input line ignores open drain until it turns output
         assign od_w[i] = bus.open_drain[i] & bus.dir[i]; // RULE7 RULE8
      end
   endgenerate

   always_comb begin
      d = q;
      if (bus.ce) begin
         d.od = od_w;
         d.pu = bus.pull_up; // RULE11
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bus.od_active = q.od;
   assign bus.pu_active = q.pu;
endmodule
`default_nettype wire

// File: rtl/gpio_pad_cfg.sv
// Purpose: high-drive, open-drain and pull-up registers of one port
// Assumes: neighbour registers report writes of 1 as one-cycle bit pulses
// Notes: set PULL_UP_RESET per port instance
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_cfg
   import gpio_pad_pkg::*;
#(
   parameter logic [LINES-1:0] PULL_UP_RESET = PULL_UP_RESET_PLAIN
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic [LINES-1:0] dir_bits,
   input wire logic [LINES-1:0] low_drive_set,
   input wire logic [LINES-1:0] medium_drive_set,
   input wire logic [LINES-1:0] pull_down_set,
   output logic [LINES-1:0] low_medium_clr,
   output logic [LINES-1:0] pull_down_clr,
   output logic [LINES-1:0] high_drive_bits,
   output logic [LINES-1:0] open_drain_bits,
   output logic [LINES-1:0] pull_up_bits,
   output logic [LINES-1:0] pad_open_drain,
   output logic [LINES-1:0] pad_pull_up
);
   typedef struct packed {
      logic [LINES-1:0] high_drive;
      logic [LINES-1:0] open_drain;
      logic [LINES-1:0] pull_up;
      logic [LINES-1:0] lm_clr;
      logic [LINES-1:0] pd_clr;
      logic [DATA_W-1:0] rdata;
   } core_t;
   core_t q, d;

   pad_cfg_if #(.LINES(LINES)) link ();

   assign link.ce = ce;
   assign link.drive_req = low_drive_set | medium_drive_set; // RULE3
   assign link.pull_req = pull_down_set; // RULE13
   assign link.open_drain = q.open_drain;
   assign link.pull_up = q.pull_up;
   assign link.dir = dir_bits;

   cross_clear_stage #(.LINES(LINES)) u_stage (
      .mclk(mclk),
      .rstn(rstn),
      .bus(link)
   );

   pad_ctrl_out #(.LINES(LINES)) u_pads (
      .mclk(mclk),
      .rstn(rstn),
      .bus(link)
   );

   function automatic logic [DATA_W-1:0] widen(input logic [LINES-1:0] f);
      widen = {{(DATA_W-LINES){1'b0}}, f}; // RULE5
   endfunction

   always_comb begin
      d = q;
      if (ce) begin
         // outgoing clears are one-cycle pulses; neighbours apply them next edge
         d.lm_clr = '0;
         d.pd_clr = '0;
         d.rdata = '0;
         // staged neighbour clears land now, the second cycle after their write
         d.high_drive = q.high_drive & ~link.drive_clr; // RULE3
         d.pull_up = q.pull_up & ~link.pull_clr; // RULE13
         if (wr) begin
            // a fresh write is newer than a staged clear, so it wins
            if (addr == HIGH_DRIVE_OFS) begin
               d.high_drive = wdata[LINES-1:0]; // RULE1 RULE4
               d.lm_clr = wdata[LINES-1:0]; // RULE2 RULE16
            end else if (addr == OPEN_DRAIN_OFS) begin
               d.open_drain = wdata[LINES-1:0]; // RULE6
            end else if (addr == PULL_UP_OFS) begin
               d.pull_up = wdata[LINES-1:0]; // RULE11
               d.pd_clr = wdata[LINES-1:0]; // RULE12 RULE16
            end
         end
         if (rd) begin
            // unmapped offsets read as zero
            if (addr == HIGH_DRIVE_OFS) begin
               d.rdata = widen(q.high_drive); // RULE5
            end else if (addr == OPEN_DRAIN_OFS) begin
               d.rdata = widen(q.open_drain);
            end else if (addr == PULL_UP_OFS) begin
               d.rdata = widen(q.pull_up);
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q.high_drive <= HIGH_DRIVE_RESET; // RULE4 RULE15
         q.open_drain <= OPEN_DRAIN_RESET; // RULE6
         q.pull_up <= PULL_UP_RESET; // RULE14
         q.lm_clr <= '0;
         q.pd_clr <= '0;
         q.rdata <= '0;
      end else begin
         q <= d;
      end
   end

   assign rdata = q.rdata;
   assign low_medium_clr = q.lm_clr;
   assign pull_down_clr = q.pd_clr;
   assign high_drive_bits = q.high_drive;
   assign open_drain_bits = q.open_drain;
   assign pull_up_bits = q.pull_up;
   assign pad_open_drain = link.od_active;
   assign pad_pull_up = link.pu_active;
endmodule
`default_nettype wire

// File: test/gpio_pad_cfg_sva.sv
// Purpose: port-level checker for gpio_pad_cfg
// Assumes: neighbour pulses idle during reset
// Notes: bound to every instance
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_cfg_sva
   import gpio_pad_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [LINES-1:0] dir_bits,
   input wire logic [LINES-1:0] low_drive_set,
   input wire logic [LINES-1:0] medium_drive_set,
   input wire logic [LINES-1:0] pull_down_set,
   input wire logic [LINES-1:0] low_medium_clr,
   input wire logic [LINES-1:0] pull_down_clr,
   input wire logic [LINES-1:0] high_drive_bits,
   input wire logic [LINES-1:0] open_drain_bits,
   input wire logic [LINES-1:0] pull_up_bits,
   input wire logic [LINES-1:0] pad_open_drain,
   input wire logic [LINES-1:0] pad_pull_up
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   AST_RD_HIGH: assert property (ce && rd |=> rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   AST_HD_WR: assert property (ce && wr && addr == HIGH_DRIVE_OFS |=>
      high_drive_bits == $past(wdata[7:0]) && low_medium_clr == $past(wdata[7:0])) else $error("high drive write");
   AST_OD_WR: assert property (ce && wr && addr == OPEN_DRAIN_OFS |=>
      open_drain_bits == $past(wdata[7:0])) else $error("open drain write");
   AST_PU_WR: assert property (ce && wr && addr == PULL_UP_OFS |=>
      pull_up_bits == $past(wdata[7:0]) && pull_down_clr == $past(wdata[7:0])) else $error("pull-up write");
   AST_NO_CLR: assert property (ce && !wr |=> low_medium_clr == 8'h00 && pull_down_clr == 8'h00)
      else $error("stray clear pulse");
   AST_HD_CLR: assert property (ce ##1 ce && !wr |=>
      (high_drive_bits & ($past(low_drive_set, 2) | $past(medium_drive_set, 2))) == 8'h00) else $error("drive clear");
   AST_PU_CLR: assert property (ce ##1 ce && !wr |=> (pull_up_bits & $past(pull_down_set, 2)) == 8'h00)
      else $error("pull-up clear");
   AST_PAD_OD: assert property (ce |=> pad_open_drain == ($past(open_drain_bits) & $past(dir_bits)))
      else $error("open drain pad");
   AST_PAD_PU: assert property (ce |=> pad_pull_up == $past(pull_up_bits))
      else $error("pull-up pad");
endmodule
bind gpio_pad_cfg gpio_pad_cfg_sva i_gpio_pad_cfg_sva (
   .mclk(mclk),
   .rstn(rstn),
   .ce(ce),
   .addr(addr),
   .wdata(wdata),
   .wr(wr),
   .rd(rd),
   .rdata(rdata),
   .dir_bits(dir_bits),
   .low_drive_set(low_drive_set),
   .medium_drive_set(medium_drive_set),
   .pull_down_set(pull_down_set),
   .low_medium_clr(low_medium_clr),
   .pull_down_clr(pull_down_clr),
   .high_drive_bits(high_drive_bits),
   .open_drain_bits(open_drain_bits),
   .pull_up_bits(pull_up_bits),
   .pad_open_drain(pad_open_drain),
   .pad_pull_up(pad_pull_up)
);
`default_nettype wire

// File: test/gpio_pad_drive_pull_config_test.sv
// Purpose: directed bench for gpio_pad_cfg
// Assumes: port C pull-up reset, ce high except in the freeze scenario
// Notes: the bench drives the neighbour pulses and direction bits itself
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_drive_pull_config_test
   import gpio_pad_pkg::*;
;
   logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata;
   logic [LINES-1:0] dir_bits = '0, low_drive_set = '0, medium_drive_set = '0, pull_down_set = '0;
   logic [LINES-1:0] low_medium_clr, pull_down_clr, high_drive_bits, open_drain_bits, pull_up_bits;
   logic [LINES-1:0] pad_open_drain, pad_pull_up;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   always #10 mclk = ~mclk;
   gpio_pad_cfg #(.PULL_UP_RESET(PULL_UP_RESET_PORT_C)) i_gpio_pad_cfg (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .dir_bits(dir_bits),
      .low_drive_set(low_drive_set),
      .medium_drive_set(medium_drive_set),
      .pull_down_set(pull_down_set),
      .low_medium_clr(low_medium_clr),
      .pull_down_clr(pull_down_clr),
      .high_drive_bits(high_drive_bits),
      .open_drain_bits(open_drain_bits),
      .pull_up_bits(pull_up_bits),
      .pad_open_drain(pad_open_drain),
      .pad_pull_up(pad_pull_up)
   );
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic chkreg(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata, {24'h000000, exp});
   endtask
   task automatic t_reset;
      chkreg(HIGH_DRIVE_OFS, 8'h00);
      chkreg(OPEN_DRAIN_OFS, 8'h00);
      chkreg(PULL_UP_OFS, 8'h0F);
      chk({24'h000000, pad_pull_up}, 32'h0000000F);
   endtask
   task automatic t_rw;
      wreg(HIGH_DRIVE_OFS, 32'hFFFFFF5A);
      wreg(OPEN_DRAIN_OFS, 32'h000000A5);
      wreg(PULL_UP_OFS, 32'h0000003C);
      wreg(12'h514, 32'h000000FF);
      chkreg(HIGH_DRIVE_OFS, 8'h5A);
      chkreg(OPEN_DRAIN_OFS, 8'hA5);
      chkreg(PULL_UP_OFS, 8'h3C);
      chkreg(12'h514, 8'h00);
   endtask
   task automatic t_clear;
      wreg(HIGH_DRIVE_OFS, 32'h000000FF);
      #1 chk({24'h000000, low_medium_clr}, 32'h000000FF);
      wreg(PULL_UP_OFS, 32'h000000FF);
      #1 chk({24'h000000, pull_down_clr}, 32'h000000FF);
      @(posedge mclk);
      low_drive_set <= 8'h04;
      medium_drive_set <= 8'h80;
      pull_down_set <= 8'h10;
      @(posedge mclk);
      low_drive_set <= 8'h00;
      medium_drive_set <= 8'h00;
      pull_down_set <= 8'h00;
      #1 chk({24'h000000, high_drive_bits}, 32'h000000FF);
      @(posedge mclk);
      #1 chk({24'h000000, high_drive_bits}, 32'h0000007B);
      chk({24'h000000, pull_up_bits}, 32'h000000EF);
      chk({24'h000000, open_drain_bits}, 32'h000000A5);
      // zero bits of a write must raise no clear pulse
      wreg(HIGH_DRIVE_OFS, 32'h0000000F);
      #1 chk({24'h000000, low_medium_clr}, 32'h0000000F);
      chk({24'h000000, high_drive_bits}, 32'h0000000F);
   endtask
   task automatic t_dir;
      // digital enable and alternate function live in the neighbour registers
      wreg(OPEN_DRAIN_OFS, 32'h000000FF);
      repeat (2) @(posedge mclk);
      #1 chk({24'h000000, pad_open_drain}, 32'h00000000);
      @(posedge mclk);
      dir_bits <= 8'h0F;
      repeat (2) @(posedge mclk);
      #1 chk({24'h000000, pad_open_drain}, 32'h0000000F);
   endtask
   task automatic t_freeze;
      @(posedge mclk);
      ce <= 1'b0;
      dir_bits <= 8'hF0;
      // a write while frozen is lost, pads hold their last value
      wreg(OPEN_DRAIN_OFS, 32'h00000000);
      #1 chk({24'h000000, open_drain_bits}, 32'h000000FF);
      chk({24'h000000, pad_open_drain}, 32'h0000000F);
      @(posedge mclk);
      ce <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk({24'h000000, pad_open_drain}, 32'h000000F0);
      chkreg(OPEN_DRAIN_OFS, 8'hFF);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_rw();
      t_clear();
      t_dir();
      t_freeze();
      summarize();
   end
   // generous ceiling, the tests need under sixty cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         summarize();
      end
   end
endmodule
`default_nettype wire
